/* File: logic/mids_consts.svh */
// Constants of the interpolation mode, command data and main status register bank.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef MIDS_CONSTS_SVH
`define MIDS_CONSTS_SVH

// ****************************************
// Register word indices
// ****************************************
`define MIDS_WORD_W 3
`define MIDS_OFS_MAIN_STATUS 3'h0
`define MIDS_OFS_INTERP_MODE 3'h5
`define MIDS_OFS_CMD_LOW 3'h6
`define MIDS_OFS_CMD_HIGH 3'h7

// ****************************************
// Widths and reset values
// ****************************************
`define MIDS_REG_W 16
`define MIDS_BYTE_W 8
`define MIDS_OPERAND_W 32
`define MIDS_OPERAND_BYTES 4
`define MIDS_MODE_RESET 16'h0000
`define MIDS_RD_IDLE 16'h0000
`define MIDS_BYTE_ZERO 8'h00

// ****************************************
// Field codes
// ****************************************
`define MIDS_VSPD_NONE 2'h0
`define MIDS_VSPD_TWO_AXIS 2'h1
`define MIDS_ZERO2 2'h0
`define MIDS_ZERO1 1'h0

`endif

/* File: logic/mids_pkg.sv */
// Types of the interpolation mode, command data and main status register bank.
// Assumes mids_consts.svh is on the include path.
`include "mids_consts.svh"

package mids_pkg;

   // ****************************************
   // Register layouts
   // ****************************************
   typedef enum logic [1:0] {
      VSPD_NONE = 2'b00,
      VSPD_TWO_AXIS = 2'b01,
      VSPD_BAD_A = 2'b10,
      VSPD_BAD_B = 2'b11
   } mids_vector_speed_t;

   typedef enum logic [1:0] {
      MLT_OFF = 2'b00,
      MLT_MAIN = 2'b01,
      MLT_SUB_XY = 2'b10,
      MLT_SUB_X = 2'b11
   } mids_multichip_t;

   typedef struct packed {
      logic patternInterpIrqEnable;
      logic interpIrqEnable;
      logic commandSingleStepEnable;
      logic externalSingleStepEnable;
      mids_multichip_t multichipRole;
      mids_vector_speed_t vectorSpeedSelect;
      logic [7:0] reservedLow;
   } mids_mode_t;

   typedef struct packed {
      logic unusedTop;
      logic [1:0] patternStackCount;
      logic [2:0] circleZone;
      logic nextNodeReady;
      logic interpDrivingFlag;
      logic [1:0] zeroUpper;
      logic [1:0] axisErrorFlag;
      logic [1:0] zeroLower;
      logic [1:0] axisDrivingFlag;
   } mids_status_t;

   // Per-axis causes that feed the error summary
   typedef struct packed {
      logic [6:0] errorBits;
      logic [3:0] stopCause;
   } mids_axis_err_t;

   typedef enum logic [1:0] {
      DRV_IDLE = 2'b00,
      DRV_PULSE = 2'b01,
      DRV_SETTLE = 2'b10
   } mids_drive_state_t;

endpackage

/* File: logic/mids_operand_store.sv */
// Byte-wide store of the 32-bit command operand with a registered output.
// Assumes the owner supplies per-byte write enables and lane data.
`timescale 1ns/1ns
`include "mids_consts.svh"

module mids_operand_store #(
   parameter int BYTES = `MIDS_OPERAND_BYTES
) (
   // Clock
   input logic clk,
   // Write side
   input logic [BYTES-1:0] byteWrite,
   input logic [BYTES*`MIDS_BYTE_W-1:0] laneData,
   // Operand out
   output logic [BYTES*`MIDS_BYTE_W-1:0] operandOut
);

   // ****************************************
   // Storage
   // ****************************************
   // No reset here: contents keep their last written value through reset
   logic [`MIDS_BYTE_W-1:0] mem_q [BYTES];
   logic [`MIDS_BYTE_W-1:0] mem_d [BYTES];
   logic [BYTES*`MIDS_BYTE_W-1:0] operand_d;
   logic [BYTES*`MIDS_BYTE_W-1:0] operand_q;

   always_comb begin
      operand_d = '0;
      for (int i = 0; i < BYTES; i++) begin
         mem_d[i] = byteWrite[i] ? laneData[i*`MIDS_BYTE_W +: `MIDS_BYTE_W] : mem_q[i];
         operand_d[i*`MIDS_BYTE_W +: `MIDS_BYTE_W] = mem_d[i];
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < BYTES; i++) begin
         mem_q[i] <= mem_d[i];
      end
      operand_q <= operand_d;
   end

   assign operandOut = operand_q;

endmodule // mids_operand_store

/* File: logic/mids_regs.sv */
// Interpolation mode, command data and main status registers of a two-axis controller.
// Assumes a host port with one-cycle strobes and status inputs synchronous to clk.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "mids_consts.svh"

module mids_regs
   import mids_pkg::*;
#(
   parameter int ADDR_W = `MIDS_WORD_W + 1,
   parameter int AXES = 2
) (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Host register port
   input logic [ADDR_W-1:0] busAddr,
   input logic [`MIDS_REG_W-1:0] busWrData,
   input logic busWr,
   input logic busRd,
   input logic busByteMode,
   output logic [`MIDS_REG_W-1:0] busRdData,
   // Axis drive status from the pulse generators
   input logic [AXES-1:0] axisPulseActive,
   input logic [AXES-1:0] servoInPositionUse,
   input logic [AXES-1:0] servoInPositionInput,
   input mids_axis_err_t [AXES-1:0] axisErrorStatus,
   // Interpolator status
   input logic interpPulseActive,
   input logic nextNodeReady,
   input logic [2:0] circleZone,
   input logic [1:0] patternStackCounter,
   input logic interpIrqEvent,
   input logic patternIrqEvent,
   // Single-step sources
   input logic singleStepPulseInput,
   input logic singleStepCommand,
   // Configuration to the interpolator
   output mids_mode_t interpolationMode,
   output logic constantVectorSpeedOn,
   output mids_multichip_t multichipRole,
   output logic interpStepAdvance,
   output logic interpIrqRequest,
   output logic patternIrqRequest,
   // Command operand
   output logic signed [`MIDS_OPERAND_W-1:0] commandOperandBits
);

   // ****************************************
   // Address decode
   // ****************************************
   // Word index: in byte mode the lowest address bit picks the byte lane
   function automatic logic [`MIDS_WORD_W-1:0] wordIndex(input logic [ADDR_W-1:0] addr, input logic byteMode);
      wordIndex = byteMode ? addr[`MIDS_WORD_W:1] : addr[`MIDS_WORD_W-1:0];
   endfunction

   // Lane enables of one word: bit 0 low byte, bit 1 high byte
   function automatic logic [1:0] laneEnable(input logic [ADDR_W-1:0] addr, input logic byteMode);
      if (!byteMode) begin
         laneEnable = 2'h3;
      end else begin
         laneEnable = addr[0] ? 2'h2 : 2'h1;
      end
   endfunction

   logic [`MIDS_WORD_W-1:0] wrWord;
   logic [1:0] wrLanes;
   logic [`MIDS_REG_W-1:0] wrLaneData;
   logic [`MIDS_WORD_W-1:0] rdWord;
   logic [1:0] rdLanes;

   always_comb begin
      wrWord = wordIndex(busAddr, busByteMode);
      wrLanes = laneEnable(busAddr, busByteMode);
      rdWord = wordIndex(busAddr, busByteMode);
      rdLanes = laneEnable(busAddr, busByteMode);
      // Byte data arrives on the low lane and is mirrored to the high lane
      wrLaneData = busByteMode ? {busWrData[`MIDS_BYTE_W-1:0], busWrData[`MIDS_BYTE_W-1:0]} : busWrData;
   end

   // ****************************************
   // Interpolation mode register
   // ****************************************
   mids_mode_t mode_d;
   mids_mode_t mode_q;
   logic [`MIDS_REG_W-1:0] modeMerged;

   always_comb begin
      modeMerged = mode_q;
      if (wrLanes[0]) begin
         modeMerged[`MIDS_BYTE_W-1:0] = wrLaneData[`MIDS_BYTE_W-1:0];
      end
      if (wrLanes[1]) begin
         modeMerged[`MIDS_REG_W-1:`MIDS_BYTE_W] = wrLaneData[`MIDS_REG_W-1:`MIDS_BYTE_W];
      end
      mode_d = mode_q;
      if (busWr && wrWord == `MIDS_OFS_INTERP_MODE) begin
         mode_d = mids_mode_t'(modeMerged);
         // Low byte is reserved and always holds zero
         mode_d.reservedLow = `MIDS_BYTE_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q <= mids_mode_t'(`MIDS_MODE_RESET);
      end else begin
         mode_q <= mode_d;
      end
   end

   assign interpolationMode = mode_q;
   // Invalid codes fall back to no constant vector speed
   assign constantVectorSpeedOn = (mode_q.vectorSpeedSelect == VSPD_TWO_AXIS);
   assign multichipRole = mode_q.multichipRole;

   // ****************************************
   // Command data registers
   // ****************************************
   // Each byte stores on its own strobe, so write order does not matter
   logic [`MIDS_OPERAND_BYTES-1:0] operandByteWrite;
   logic [`MIDS_OPERAND_W-1:0] operandStored;

   always_comb begin
      operandByteWrite = '0;
      if (busWr && wrWord == `MIDS_OFS_CMD_LOW) begin
         operandByteWrite[1:0] = wrLanes;
      end
      if (busWr && wrWord == `MIDS_OFS_CMD_HIGH) begin
         operandByteWrite[3:2] = wrLanes;
      end
   end

   mids_operand_store #(
      .BYTES(`MIDS_OPERAND_BYTES)
   ) operandStore (
      .clk(clk),
      .byteWrite(operandByteWrite),
      .laneData({wrLaneData, wrLaneData}),
      .operandOut(operandStored)
   );

   // Left unreset on purpose; the store has no reset port
   assign commandOperandBits = $signed(operandStored);

   // ****************************************
   // Axis driving flags
   // ****************************************
   // A servo axis holds its flag until the drive reports in-position
   mids_drive_state_t [AXES-1:0] drv_d;
   mids_drive_state_t [AXES-1:0] drv_q;
   logic [AXES-1:0] drivingFlag;

   always_comb begin
      drv_d = drv_q;
      for (int a = 0; a < AXES; a++) begin
         unique case (drv_q[a])
            DRV_IDLE: begin
               if (axisPulseActive[a]) begin
                  drv_d[a] = DRV_PULSE;
               end
            end
            DRV_PULSE: begin
               if (!axisPulseActive[a]) begin
                  if (servoInPositionUse[a] && !servoInPositionInput[a]) begin
                     drv_d[a] = DRV_SETTLE;
                  end else begin
                     drv_d[a] = DRV_IDLE;
                  end
               end
            end
            DRV_SETTLE: begin
               if (axisPulseActive[a]) begin
                  drv_d[a] = DRV_PULSE;
               end else if (!servoInPositionUse[a] || servoInPositionInput[a]) begin
                  drv_d[a] = DRV_IDLE;
               end
            end
            default: begin
               drv_d[a] = DRV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int a = 0; a < AXES; a++) begin
            drv_q[a] <= DRV_IDLE;
         end
      end else begin
         drv_q <= drv_d;
      end
   end

   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         drivingFlag[a] = (drv_q[a] != DRV_IDLE);
      end
   end

   // ****************************************
   // Main status snapshot
   // ****************************************
   mids_status_t status_d;
   mids_status_t status_q;

   always_comb begin
      status_d = '0;
      status_d.unusedTop = `MIDS_ZERO1;
      status_d.zeroUpper = `MIDS_ZERO2;
      status_d.zeroLower = `MIDS_ZERO2;
      for (int a = 0; a < AXES; a++) begin
         status_d.axisErrorFlag[a] = (|axisErrorStatus[a].errorBits) | (|axisErrorStatus[a].stopCause);
      end
      status_d.axisDrivingFlag = drivingFlag;
      status_d.interpDrivingFlag = interpPulseActive;
      status_d.nextNodeReady = nextNodeReady;
      status_d.circleZone = circleZone;
      // 3 full, 2 one word free, 1 two free, 0 empty and finished
      status_d.patternStackCount = patternStackCounter;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // Write-only registers and unmapped words read as zero
   logic [`MIDS_REG_W-1:0] rdWordData;
   logic [`MIDS_REG_W-1:0] rdData_d;
   logic [`MIDS_REG_W-1:0] rdData_q;

   always_comb begin
      rdWordData = (rdWord == `MIDS_OFS_MAIN_STATUS) ? status_q : `MIDS_RD_IDLE;
      rdData_d = `MIDS_RD_IDLE;
      if (busRd) begin
         unique case (rdLanes)
            2'h1: rdData_d = {`MIDS_BYTE_ZERO, rdWordData[`MIDS_BYTE_W-1:0]};
            2'h2: rdData_d = {`MIDS_BYTE_ZERO, rdWordData[`MIDS_REG_W-1:`MIDS_BYTE_W]};
            2'h3: rdData_d = rdWordData;
            default: rdData_d = `MIDS_RD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_q <= `MIDS_RD_IDLE;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign busRdData = rdData_q;

   // ****************************************
   // Single step and interrupt gating
   // ****************************************
   // Only the rising edge counts, so a held pulse input gives one step
   logic stepIn_d;
   logic stepIn_q;
   logic step_d;
   logic step_q;
   logic interpIrq_d;
   logic interpIrq_q;
   logic patternIrq_d;
   logic patternIrq_q;

   always_comb begin
      stepIn_d = singleStepPulseInput;
      step_d = (mode_q.externalSingleStepEnable && singleStepPulseInput && !stepIn_q)
         || (mode_q.commandSingleStepEnable && singleStepCommand);
      interpIrq_d = mode_q.interpIrqEnable && interpPulseActive && interpIrqEvent;
      patternIrq_d = mode_q.patternInterpIrqEnable && interpPulseActive && patternIrqEvent;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stepIn_q <= 1'b0;
         step_q <= 1'b0;
         interpIrq_q <= 1'b0;
         patternIrq_q <= 1'b0;
      end else begin
         stepIn_q <= stepIn_d;
         step_q <= step_d;
         interpIrq_q <= interpIrq_d;
         patternIrq_q <= patternIrq_d;
      end
   end

   assign interpStepAdvance = step_q;
   assign interpIrqRequest = interpIrq_q;
   assign patternIrqRequest = patternIrq_q;

endmodule // mids_regs

/* File: tb/mids_regs_assertions.sv */
// Port-level checks of the mode, operand and main status register bank.
// Assumes it is bound to mids_regs and shares its clock and reset.
`timescale 1ns/1ns
`include "mids_consts.svh"

module mids_regs_assertions
   import mids_pkg::*;
#(
   parameter int ADDR_W = 4,
   parameter int AXES = 2
) (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Host port
   input logic [ADDR_W-1:0] busAddr,
   input logic [`MIDS_REG_W-1:0] busWrData,
   input logic busWr,
   input logic busRd,
   input logic busByteMode,
   input logic [`MIDS_REG_W-1:0] busRdData,
   // Status and step sources
   input logic [AXES-1:0] axisPulseActive,
   input logic [AXES-1:0] servoInPositionUse,
   input logic [AXES-1:0] servoInPositionInput,
   input mids_axis_err_t [AXES-1:0] axisErrorStatus,
   input logic interpPulseActive,
   input logic nextNodeReady,
   input logic [2:0] circleZone,
   input logic [1:0] patternStackCounter,
   input logic interpIrqEvent,
   input logic patternIrqEvent,
   input logic singleStepPulseInput,
   input logic singleStepCommand,
   // Outputs
   input mids_mode_t interpolationMode,
   input logic constantVectorSpeedOn,
   input mids_multichip_t multichipRole,
   input logic interpStepAdvance,
   input logic interpIrqRequest,
   input logic patternIrqRequest
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Guard keeps the reset-time snapshot out of the comparison
   sequence s_rdStatus; busRd && !busByteMode && busAddr[2:0] == 3'h0 && !$past(sys_rst); endsequence
   sequence s_wrMode; busWr && !busByteMode && busAddr[2:0] == 3'h5; endsequence
   sequence s_settling; !axisPulseActive[0] && servoInPositionUse[0] && !servoInPositionInput[0]; endsequence

   property p_modeReset; disable iff (1'b0) sys_rst |=> interpolationMode == `MIDS_MODE_RESET; endproperty
   a_modeReset: assert property (p_modeReset) else $error("mode not cleared by reset");
   property p_vspeed; s_wrMode |=> constantVectorSpeedOn == ($past(busWrData[9:8]) == 2'h1); endproperty
   a_vspeed: assert property (p_vspeed) else $error("vector speed select wrong");
   property p_role; s_wrMode |=> multichipRole == $past(busWrData[11:10]); endproperty
   a_role: assert property (p_role) else $error("multichip role wrong");
   property p_extStep; interpolationMode[12] && $rose(singleStepPulseInput) |=> interpStepAdvance; endproperty
   a_extStep: assert property (p_extStep) else $error("external step lost");
   property p_cmdStep; interpolationMode[13] && singleStepCommand |=> interpStepAdvance; endproperty
   a_cmdStep: assert property (p_cmdStep) else $error("command step lost");
   property p_irq; interpolationMode[14] && interpPulseActive && interpIrqEvent |=> interpIrqRequest; endproperty
   a_irq: assert property (p_irq) else $error("interp irq lost");
   property p_patIrq; !interpolationMode[15] |=> !patternIrqRequest; endproperty
   a_patIrq: assert property (p_patIrq) else $error("pattern irq while disabled");
   property p_fields;
      s_rdStatus |=> busRdData[15:8] == {1'b0, $past({patternStackCounter, circleZone, nextNodeReady, interpPulseActive}, 2)};
   endproperty
   a_fields: assert property (p_fields) else $error("status fields wrong");
   property p_err; s_rdStatus |=> busRdData[5:4] == $past({|axisErrorStatus[1], |axisErrorStatus[0]}, 2); endproperty
   a_err: assert property (p_err) else $error("error summary wrong");
   property p_drvHold; axisPulseActive[0] [*4] ##1 s_settling [*4] ##0 s_rdStatus |=> busRdData[0]; endproperty
   a_drvHold: assert property (p_drvHold) else $error("driving cleared before in position");
endmodule // mids_regs_assertions

bind mids_regs mids_regs_assertions #(.ADDR_W(ADDR_W), .AXES(AXES)) chk (.clk, .sys_rst, .busAddr, .busWrData,
   .busWr, .busRd, .busByteMode, .busRdData, .axisPulseActive, .servoInPositionUse, .servoInPositionInput,
   .axisErrorStatus, .interpPulseActive, .nextNodeReady, .circleZone, .patternStackCounter, .interpIrqEvent,
   .patternIrqEvent, .singleStepPulseInput, .singleStepCommand, .interpolationMode, .constantVectorSpeedOn,
   .multichipRole, .interpStepAdvance, .interpIrqRequest, .patternIrqRequest);

/* File: tb/mids_host_model.sv */
// Host processor model: one-cycle write and read strobes on the register port.
// Assumes the bank answers reads in the cycle after the strobe.
`timescale 1ns/1ns
`include "mids_consts.svh"

module mids_host_model (
   // Clock
   input logic clk,
   // Register port
   output logic [3:0] busAddr,
   output logic [`MIDS_REG_W-1:0] busWrData,
   output logic busWr,
   output logic busRd,
   output logic busByteMode,
   input logic [`MIDS_REG_W-1:0] busRdData
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      busAddr = 4'h0;
      busWrData = 16'h0000;
      busWr = 1'h0;
      busRd = 1'h0;
      busByteMode = 1'h0;
   end

   // Data inverted after the strobe so a late sample is seen as wrong
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic byteMode);
      @(posedge clk);
      busByteMode <= byteMode;
      busAddr <= a;
      busWrData <= d;
      busWr <= 1'h1;
      @(posedge clk);
      busWr <= 1'h0;
      busWrData <= ~d;
   endtask

   task automatic rd(input logic [3:0] a, input logic byteMode, output logic [15:0] d);
      @(posedge clk);
      busByteMode <= byteMode;
      busAddr <= a;
      busRd <= 1'h1;
      @(posedge clk);
      busRd <= 1'h0;
      @(negedge clk);
      d = busRdData;
   endtask

   // Whole operand, two's complement as given, either order
   task automatic wr32(input logic [31:0] v, input logic hiFirst, input logic byteMode);
      int idx;
      for (int k = 0; k < (byteMode ? 4 : 2); k++) begin
         idx = hiFirst ? (byteMode ? 3 : 1) - k : k;
         if (byteMode) begin
            wr(4'(12 + idx), {8'h00, v[8*idx +: 8]}, 1'h1);
         end else begin
            wr(4'(6 + idx), v[16*idx +: 16], 1'h0);
         end
      end
   endtask
endmodule // mids_host_model

/* File: tb/testbench.sv */
// Self-checking bench of the register bank with a host model on its port.
// Assumes the design defaults: two axes, four address bits.
`timescale 1ns/1ns
`include "mids_consts.svh"

module testbench
   import mids_pkg::*;
;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [3:0] busAddr;
   logic [15:0] busWrData, busRdData, rdv;
   logic busWr, busRd, busByteMode;
   logic [1:0] axisPulseActive = 2'h0, servoInPositionUse = 2'h0, servoInPositionInput = 2'h0;
   mids_axis_err_t [1:0] axisErrorStatus = 22'h000000;
   logic interpPulseActive = 1'h0, nextNodeReady = 1'h0, interpIrqEvent = 1'h0, patternIrqEvent = 1'h0;
   logic singleStepPulseInput = 1'h0, singleStepCommand = 1'h0;
   logic [2:0] circleZone = 3'h0;
   logic [1:0] patternStackCounter = 2'h0;
   mids_mode_t interpolationMode;
   mids_multichip_t multichipRole;
   logic constantVectorSpeedOn, interpStepAdvance, interpIrqRequest, patternIrqRequest;
   logic signed [31:0] commandOperandBits;
   int fails = 0, checksDone = 0, cycles = 0;

   mids_regs uut (.clk, .sys_rst, .busAddr, .busWrData, .busWr, .busRd, .busByteMode, .busRdData,
      .axisPulseActive, .servoInPositionUse, .servoInPositionInput, .axisErrorStatus, .interpPulseActive,
      .nextNodeReady, .circleZone, .patternStackCounter, .interpIrqEvent, .patternIrqEvent,
      .singleStepPulseInput, .singleStepCommand, .interpolationMode, .constantVectorSpeedOn, .multichipRole,
      .interpStepAdvance, .interpIrqRequest, .patternIrqRequest, .commandOperandBits);
   mids_host_model host (.clk, .busAddr, .busWrData, .busWr, .busRd, .busByteMode, .busRdData);

   always #50 clk = ~clk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A hang counts as a mismatch
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_mode;
      logic [15:0] m;
      // Host keeps Y range at 1.414 times X; this block holds no range
      for (int k = 0; k < 4; k++) begin
         m = {k[1:0], ~k[1:0], k[1:0], k[1:0], 8'hA5};
         host.wr(4'h5, m, 1'h0);
         @(negedge clk);
         chk("mode", {m[15:8], 8'h00}, interpolationMode);
         chk("speed on", 32'(k == 1), constantVectorSpeedOn);
         chk("role", 32'(k), multichipRole);
      end
      host.wr(4'h3, 16'h0000, 1'h0);
      host.rd(4'h5, 1'h0, rdv);
      chk("write-only read", 32'h0, rdv);
      chk("unmapped write", 32'hCF00, interpolationMode);
      host.wr(4'hB, 16'h0012, 1'h1);
      @(negedge clk);
      chk("mode high byte", 32'h1200, interpolationMode);
   endtask

   task automatic t_reset;
      @(posedge clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      chk("mode after reset", 32'h0, interpolationMode);
      chk("operand kept", 32'h80000001, commandOperandBits);
   endtask

   task automatic t_operand;
      logic [31:0] v [4] = '{32'h12345678, 32'hFF800000, 32'h007FFFFF, 32'h80000001};
      for (int k = 0; k < 4; k++) begin
         host.wr32(v[k], k[0], k[1]);
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("operand", v[k], commandOperandBits);
      end
   endtask

   task automatic t_status;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         circleZone <= 3'(i);
         patternStackCounter <= 2'(i);
         nextNodeReady <= i[0];
         interpPulseActive <= i[1];
         axisPulseActive <= 2'(i);
         axisErrorStatus[0] <= (i == 7) ? 11'h008 : 11'h010 << i;
         axisErrorStatus[1] <= {7'h00, 4'(i)};
         repeat (6) @(posedge clk);
         host.rd(4'h0, 1'h0, rdv);
         chk("status", {1'h0, 2'(i), 3'(i), i[0], i[1], 2'h0, i != 0, 1'h1, 2'h0, 2'(i)}, rdv);
         host.rd(4'h1, 1'h1, rdv);
         chk("status high byte", {8'h00, 1'h0, 2'(i), 3'(i), i[0], i[1]}, rdv);
      end
   endtask

   task automatic t_inpos;
      @(posedge clk);
      axisPulseActive <= 2'h1;
      servoInPositionUse <= 2'h1;
      repeat (5) @(posedge clk);
      axisPulseActive <= 2'h0;
      repeat (2) @(posedge clk);
      host.rd(4'h0, 1'h0, rdv);
      chk("driving settling", 32'h1, rdv[1:0]);
      @(posedge clk);
      servoInPositionInput <= 2'h1;
      repeat (5) @(posedge clk);
      host.rd(4'h0, 1'h0, rdv);
      chk("driving done", 32'h0, rdv[1:0]);
   endtask

   task automatic t_step;
      int n;
      for (int k = 0; k < 4; k++) begin
         host.wr(4'h5, {2'h0, k[0] & k[1], k[0] & ~k[1], 12'h000}, 1'h0);
         @(posedge clk);
         if (k[1]) singleStepCommand <= 1'h1;
         else singleStepPulseInput <= 1'h1;
         @(posedge clk);
         singleStepCommand <= 1'h0;
         n = 0;
         repeat (6) begin
            @(negedge clk);
            n += (interpStepAdvance === 1'h1);
         end
         @(posedge clk);
         singleStepPulseInput <= 1'h0;
         chk("step pulses", 32'(k[0]), 32'(n));
      end
   endtask

   task automatic t_irq;
      for (int k = 0; k < 4; k++) begin
         host.wr(4'h5, {k[1], k[0], 14'h0000}, 1'h0);
         @(posedge clk);
         interpPulseActive <= 1'h1;
         interpIrqEvent <= 1'h1;
         patternIrqEvent <= 1'h1;
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("interp irq", 32'(k[0]), interpIrqRequest);
         chk("pattern irq", 32'(k[1]), patternIrqRequest);
      end
   endtask

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      chk("mode at reset", 32'h0, interpolationMode);
      t_mode();
      t_operand();
      t_reset();
      t_status();
      t_inpos();
      t_step();
      t_irq();
      report_and_stop();
   end
endmodule // testbench
